/* File: logic/pbbr_core.sv */
// Backend burst engine: write pacing plus read-ahead with recovery store.
// How it works
// - Dropping held ready allows two more writes.
// - Burst reads fetch backend words ahead of bus.
// - More words may be fetched than delivered.
// - Without recovery, undelivered prefetched words are discarded.
// - Region setting value two selects recovery.
// - Retained words go first on next same-region read.
// - Recovery logic keeps FIFO backend data safe until another region starts a read.
// - Ready gives target ready, then write strobe.
// - Latency select zero: two words kept ahead.
// - Fetching stops before the store would overflow.
// - Latency select one: three words kept ahead.
`timescale 1ns/10ps
module pbbr_core #(
	parameter logic [15:0] REGION_ENABLE_SETTING = pbbr_pkg::REGION_SETTING_DEFAULT,
	parameter int DEPTH = pbbr_pkg::FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire pbbr_pkg::pbbr_req_s rd_req_i,
	input wire logic rd_end_i,
	input wire logic rd_take_i,
	input wire logic rd_sync_i,
	output logic [pbbr_pkg::DATA_W-1:0] rd_data_o,
	output logic rd_valid_o,
	output logic be_rd_strobe_o,
	output logic [pbbr_pkg::ADDR_W-1:0] be_addr_o,
	input wire logic [pbbr_pkg::DATA_W-1:0] be_rd_data_i,
	output logic [pbbr_pkg::CNT_W-1:0] retained_count_o,
	input wire logic wr_cycle_i,
	input wire logic pci_irdy_i,
	input wire logic [pbbr_pkg::DATA_W-1:0] wr_data_i,
	input wire logic backend_write_ready_i,
	output logic target_ready_o,
	output logic backend_write_strobe_o,
	output logic [pbbr_pkg::DATA_W-1:0] be_wr_data_o
);
	// Read engine state and the region of the cycle in progress.
	pbbr_pkg::pbbr_state_e state_ff;
	logic [2:0] cur_region_ff;
	// Retained words are valid and belong to this region.
	logic keep_ff;
	logic [2:0] kept_region_ff;
	// Address of the next backend word to fetch.
	logic [pbbr_pkg::ADDR_W-1:0] next_addr_ff;
	logic [pbbr_pkg::ADDR_W-1:0] addr_ff;
	// Backend read pipeline: strobe, then one or two data return stages.
	logic strobe_ff;
	logic stage1_ff;
	logic stage2_ff;
	// Per-region recovery flags, decoded from the region settings.
	logic [pbbr_pkg::REGION_COUNT-1:0] rec_map;
	logic cur_rec;
	// FIFO hand-shake wires.
	logic fifo_in_ready;
	logic fifo_out_ready;
	logic [pbbr_pkg::CNT_W-1:0] fifo_cnt;
	logic ret_valid;
	logic flush;
	// Read bookkeeping.
	logic [pbbr_pkg::CNT_W-1:0] inflight;
	logic [pbbr_pkg::CNT_W-1:0] ahead;
	logic [pbbr_pkg::CNT_W-1:0] look;
	// Words still ahead once the word taken by the bus this cycle has gone.
	logic taking;
	logic [pbbr_pkg::CNT_W-1:0] ahead_net;
	logic start;
	logic match;
	logic issue;
	logic drain_done;

	// One recovery flag per region.
	for (genvar i = 0; i < pbbr_pkg::REGION_COUNT; i++)
	begin : g_rec
		assign rec_map[i] = REGION_ENABLE_SETTING[i*pbbr_pkg::ENABLE_W +: pbbr_pkg::ENABLE_W]
			== pbbr_pkg::REGION_RECOVER;
	end
	assign cur_rec = rec_map[cur_region_ff];

	// Words requested from the backend whose data has not landed yet.
	assign inflight = pbbr_pkg::CNT_W'(strobe_ff) + pbbr_pkg::CNT_W'(stage1_ff)
		+ pbbr_pkg::CNT_W'(stage2_ff);
	// Words held or on their way: the read-ahead distance.
	assign ahead = fifo_cnt + inflight;
	// A word the bus takes this cycle frees its lookahead slot at once.
	// Counting it would leave the store one word short when the burst ends,
	// so the words retained for the next read would fall below the lookahead.
	assign taking = rd_valid_o && fifo_out_ready;
	assign ahead_net = ahead - pbbr_pkg::CNT_W'(taking);
	assign look = rd_sync_i ? pbbr_pkg::LOOKAHEAD_SYNC1 : pbbr_pkg::LOOKAHEAD_SYNC0;
	// Latency select picks which return stage carries the backend data.
	assign ret_valid = rd_sync_i ? stage2_ff : stage1_ff;

	// A new cycle is only accepted when the engine is idle.
	assign start = rd_req_i.start && (state_ff == pbbr_pkg::PBBR_IDLE);
	assign match = keep_ff && (rd_req_i.region == kept_region_ff);
	assign drain_done = (state_ff == pbbr_pkg::PBBR_DRAIN) && (inflight == '0);

	// Fetch ahead of the bus, limited by the lookahead and by store room.
	assign issue = (state_ff == pbbr_pkg::PBBR_FETCH) && !rd_end_i
		&& (ahead_net < look)
		&& (ahead < pbbr_pkg::CNT_W'(DEPTH)) && fifo_in_ready;

	// Plain regions lose their leftovers at the end of a cycle; any
	// retained words are also dropped when another region starts a read.
	assign flush = (start && !match) || (drain_done && !cur_rec);
	assign fifo_out_ready = rd_take_i && (state_ff == pbbr_pkg::PBBR_FETCH);

	// Read engine state sequence.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			state_ff <= pbbr_pkg::PBBR_IDLE;
		end
		else
		begin
			case (state_ff)
				pbbr_pkg::PBBR_IDLE:
				begin
					if (start)
					begin
						state_ff <= pbbr_pkg::PBBR_FETCH;
					end
				end
				pbbr_pkg::PBBR_FETCH:
				begin
					// The bus ends the cycle; words in flight still land.
					if (rd_end_i)
					begin
						state_ff <= pbbr_pkg::PBBR_DRAIN;
					end
				end
				pbbr_pkg::PBBR_DRAIN:
				begin
					if (drain_done)
					begin
						state_ff <= pbbr_pkg::PBBR_IDLE;
					end
				end
				default:
				begin
					state_ff <= pbbr_pkg::PBBR_IDLE;
				end
			endcase
		end
	end

	// Region tracking and the retained-word ownership flag.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			cur_region_ff <= 3'h0;
			keep_ff <= 1'b0;
			kept_region_ff <= 3'h0;
		end
		else if (start)
		begin
			cur_region_ff <= rd_req_i.region;
			keep_ff <= 1'b0;
		end
		else if (drain_done)
		begin
			// Recovery regions keep their leftovers for the next read.
			keep_ff <= cur_rec;
			kept_region_ff <= cur_region_ff;
		end
	end

	// Fetch address: a same-region restart continues where fetching stopped,
	// since the retained words already cover the start of the new burst.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			next_addr_ff <= 16'h0000;
			addr_ff <= 16'h0000;
		end
		else if (start && !match)
		begin
			next_addr_ff <= rd_req_i.addr;
		end
		else if (issue)
		begin
			addr_ff <= next_addr_ff;
			next_addr_ff <= next_addr_ff + pbbr_pkg::WORD_STEP;
		end
	end

	// Backend read strobe and data return pipeline.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			strobe_ff <= 1'b0;
			stage1_ff <= 1'b0;
			stage2_ff <= 1'b0;
		end
		else
		begin
			strobe_ff <= issue;
			stage1_ff <= strobe_ff;
			// The second stage only runs with the longer latency select.
			stage2_ff <= stage1_ff && rd_sync_i;
		end
	end

	// Backend side outputs come straight from their registers.
	assign be_rd_strobe_o = strobe_ff;
	assign be_addr_o = addr_ff;
	assign retained_count_o = fifo_cnt;

	// Read-ahead store; the bus side drains it, the fetch side stalls on it.
	pbbr_fifo #(
		.WIDTH(pbbr_pkg::DATA_W),
		.DEPTH(DEPTH),
		.CNT_W(pbbr_pkg::CNT_W)
	) u_fifo (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.flush_i(flush),
		.in_valid_i(ret_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(be_rd_data_i),
		.out_valid_o(rd_valid_o),
		.out_ready_i(fifo_out_ready),
		.out_data_o(rd_data_o),
		.count_o(fifo_cnt)
	);

	// Write pacing toward the backend.
	pbbr_wr_pace #(
		.DATA_W(pbbr_pkg::DATA_W)
	) u_wr (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.wr_cycle_i(wr_cycle_i),
		.irdy_i(pci_irdy_i),
		.ready_i(backend_write_ready_i),
		.data_i(wr_data_i),
		.target_ready_o(target_ready_o),
		.strobe_o(backend_write_strobe_o),
		.data_o(be_wr_data_o)
	);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	// A permitted fetch shows on the backend strobe one edge later.
	fetch_ahead_a: assert property (issue |=> be_rd_strobe_o && addr_ff == $past(next_addr_ff))
		else $error("read-ahead fetch did not reach the backend");
	// Every returned backend word finds room in the store.
	word_kept_a: assert property (ret_valid |-> fifo_in_ready)
		else $error("returned backend word had no room");
	// Plain regions end a cycle with an empty store.
	plain_flush_a: assert property (drain_done && !cur_rec |=> retained_count_o == 4'h0)
		else $error("undelivered words kept for a plain region");
	// Ownership of leftovers follows the region setting.
	region_mode_a: assert property (drain_done |=> keep_ff == $past(cur_rec))
		else $error("retained flag does not follow region setting");
	// A same-region restart loses none of the retained words.
	replay_first_a: assert property (start && match |=> retained_count_o >= $past(retained_count_o))
		else $error("retained words lost on same-region restart");
	// Idle store contents stand still between cycles.
	idle_hold_a: assert property (state_ff == pbbr_pkg::PBBR_IDLE && keep_ff && !rd_req_i.start
		|=> retained_count_o == $past(retained_count_o))
		else $error("retained words changed while idle");
	// Read-ahead distance with the short latency select.
	ahead_sync0_a: assert property (!rd_sync_i && !keep_ff |-> ahead <= pbbr_pkg::LOOKAHEAD_SYNC0)
		else $error("more than two words ahead with latency select zero");
	// The store is never asked to hold more than it has.
	no_overflow_a: assert property (ahead <= pbbr_pkg::CNT_W'(DEPTH))
		else $error("read-ahead exceeds store depth");
	// Read-ahead distance with the long latency select.
	ahead_sync1_a: assert property (rd_sync_i && !keep_ff |-> ahead <= pbbr_pkg::LOOKAHEAD_SYNC1)
		else $error("more than three words ahead with latency select one");
	// Back-to-back fetches walk the backend address one word at a time.
	addr_step_a: assert property (be_rd_strobe_o && $past(be_rd_strobe_o)
		|-> be_addr_o == $past(be_addr_o) + pbbr_pkg::WORD_STEP)
		else $error("backend fetch address did not step by one word");
	// Once the bus ends the cycle no further word is fetched, which bounds
	// the words left over to the lookahead.
	end_stop_a: assert property (rd_end_i |=> !be_rd_strobe_o)
		else $error("backend fetch issued after the read cycle ended");
	// A recovery region never keeps more words than the lookahead allows.
	retain_cap_a: assert property (drain_done && cur_rec |-> retained_count_o <= look)
		else $error("retained words exceed the lookahead");
	// Nothing is in flight while idle, so no landing word goes untracked.
	idle_quiet_a: assert property (state_ff == pbbr_pkg::PBBR_IDLE |-> inflight == '0)
		else $error("backend word in flight while the read engine is idle");

	cover property (start && match && retained_count_o != 4'h0);
	cover property (drain_done && !cur_rec && fifo_cnt != 4'h0);
	cover property (issue && rd_valid_o && rd_take_i);
	// The deepest retain, three words with the long latency select.
	cover property (drain_done && cur_rec && fifo_cnt == pbbr_pkg::LOOKAHEAD_SYNC1);
endmodule : pbbr_core

/* File: logic/pbbr_pkg.sv */
// Shared constants and types for the backend burst and read-recovery engine.
package pbbr_pkg;
	// Number of base address regions and width of each region's enable field.
	localparam int REGION_COUNT = 8;
	localparam int ENABLE_W = 2;
	// Region enable encodings: off, plain access, and read recovery.
	localparam logic [1:0] REGION_OFF = 2'h0;
	localparam logic [1:0] REGION_ON = 2'h1;
	localparam logic [1:0] REGION_RECOVER = 2'h2;
	// Data path widths and recovery store depth.
	localparam int DATA_W = 32;
	localparam int ADDR_W = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int CNT_W = 4;
	// Address step between two backend words.
	localparam logic [15:0] WORD_STEP = 16'h0004;
	// Words fetched ahead of the bus for each read latency select.
	localparam logic [3:0] LOOKAHEAD_SYNC0 = 4'h2;
	localparam logic [3:0] LOOKAHEAD_SYNC1 = 4'h3;
	// Default region setting: region 0 in recovery mode, the rest plain.
	localparam logic [15:0] REGION_SETTING_DEFAULT = 16'h5556;
	// Read engine states, Gray coded along idle, fetch, drain.
	typedef enum logic [1:0]
	{
		PBBR_IDLE = 2'b00,
		PBBR_FETCH = 2'b01,
		PBBR_DRAIN = 2'b11
	} pbbr_state_e;
	// A PCI read request as decoded by the core.
	typedef struct packed
	{
		logic start;
		logic [2:0] region;
		logic [15:0] addr;
	} pbbr_req_s;
endpackage : pbbr_pkg

/* File: logic/pbbr_fifo.sv */
// Prefetch and recovery store: a small FIFO with a registered output word.
`timescale 1ns/10ps
module pbbr_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8,
	parameter int CNT_W = 4
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic [CNT_W-1:0] count_o
);
	localparam int PTR_W = $clog2(DEPTH);
	// Storage words, write and read pointers, count of words in storage.
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PTR_W-1:0] wptr_ff;
	logic [PTR_W-1:0] rptr_ff;
	logic [CNT_W-1:0] mcnt_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic out_valid_ff;
	logic [WIDTH-1:0] out_data_ff;
	logic push;
	logic load;
	logic pop;

	// The total count includes the output word, so full is honest at DEPTH.
	assign in_ready_o = cnt_ff < CNT_W'(DEPTH);
	assign push = in_valid_i && in_ready_o;
	assign load = (mcnt_ff != '0) && (!out_valid_ff || out_ready_i);
	assign pop = out_valid_ff && out_ready_i;
	assign out_valid_o = out_valid_ff;
	assign out_data_o = out_data_ff;
	assign count_o = cnt_ff;

	// Storage writes; no reset is needed on the data words themselves.
	always_ff @(posedge clk_i)
	begin
		if (push)
		begin
			mem_ff[wptr_ff] <= in_data_i;
		end
	end

	// Pointers and counts; flush drops every word at once.
	always_ff @(posedge clk_i)
	begin
		if (reset_i || flush_i)
		begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			mcnt_ff <= '0;
			cnt_ff <= '0;
		end
		else
		begin
			wptr_ff <= push ? wptr_ff + 1'b1 : wptr_ff;
			rptr_ff <= load ? rptr_ff + 1'b1 : rptr_ff;
			mcnt_ff <= mcnt_ff + CNT_W'(push) - CNT_W'(load);
			cnt_ff <= cnt_ff + CNT_W'(push) - CNT_W'(pop);
		end
	end

	// Registered output word, refilled from storage when taken or empty.
	always_ff @(posedge clk_i)
	begin
		if (reset_i || flush_i)
		begin
			out_valid_ff <= 1'b0;
			out_data_ff <= '0;
		end
		else if (load)
		begin
			out_valid_ff <= 1'b1;
			out_data_ff <= mem_ff[rptr_ff];
		end
		else if (pop)
		begin
			out_valid_ff <= 1'b0;
		end
	end
endmodule : pbbr_fifo

/* File: logic/pbbr_wr_pace.sv */
// Write pacing: backend write-ready to target ready to backend write strobe.
`timescale 1ns/10ps
module pbbr_wr_pace #(
	parameter int DATA_W = 32
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic wr_cycle_i,
	input wire logic irdy_i,
	input wire logic ready_i,
	input wire logic [DATA_W-1:0] data_i,
	output logic target_ready_o,
	output logic strobe_o,
	output logic [DATA_W-1:0] data_o
);
	// Ready is registered twice on its way to target ready, which is why
	// a held ready that drops still lets two more words through.
	logic rdy_ff;
	logic trdy_ff;
	logic strobe_ff;
	logic [DATA_W-1:0] data_ff;

	assign target_ready_o = trdy_ff;
	assign strobe_o = strobe_ff;
	assign data_o = data_ff;

	// Ready pipeline and write strobe one edge after a bus data phase.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			rdy_ff <= 1'b0;
			trdy_ff <= 1'b0;
			strobe_ff <= 1'b0;
		end
		else
		begin
			rdy_ff <= ready_i && wr_cycle_i;
			trdy_ff <= rdy_ff && wr_cycle_i;
			strobe_ff <= trdy_ff && irdy_i;
		end
	end

	// Write data is captured with the data phase that makes the strobe.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			data_ff <= '0;
		end
		else if (trdy_ff && irdy_i)
		begin
			data_ff <= data_i;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	// Three idle ready cycles leave no write in flight.
	extra_writes_a: assert property (!ready_i [*3] |=> !strobe_o)
		else $error("write strobe more than two cycles after ready dropped");
	// A data phase is written to the backend on the next edge.
	strobe_follow_a: assert property (target_ready_o && irdy_i |=> strobe_o)
		else $error("no write strobe after target ready and initiator ready");
	cover property (ready_i ##1 !ready_i ##2 strobe_o);
endmodule : pbbr_wr_pace

/* File: test/pbbr_backend_model.sv */
// Backend partner: destructive-read FIFO source and write-ready pacer.
`timescale 1ns/10ps
module pbbr_backend_model (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic rd_sync_i,
	input wire logic rd_strobe_i,
	output logic [31:0] rd_data_o,
	input wire logic wr_en_i,
	input wire logic wr_held_i,
	input wire logic wr_strobe_i,
	output logic wr_ready_o
);
	logic [31:0] pop_ff; // Next word to pop; word k of the stream holds value k.
	logic [31:0] w1_ff;
	logic [31:0] w2_ff;
	logic v1_ff;
	logic v2_ff;
	logic [31:0] last_ff; // Last word shown, inverted when the bus is not valid.
	logic waiting_ff; // A ready pulse was given and its write has not yet shown.
	logic hit;
	logic [31:0] word;
	assign hit = rd_sync_i ? v2_ff : v1_ff;
	assign word = rd_sync_i ? w2_ff : w1_ff;
	// Outside the sample cycle the data is scrambled so a late sample is caught.
	assign rd_data_o = hit ? word : ~last_ff;
	// Every strobe pops a word, so a word fetched and then dropped is lost for good.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			pop_ff <= 32'h0;
			v1_ff <= 1'b0;
			v2_ff <= 1'b0;
			last_ff <= 32'h0;
		end
		else
		begin
			pop_ff <= pop_ff + 32'(rd_strobe_i);
			v1_ff <= rd_strobe_i;
			v2_ff <= v1_ff;
			w1_ff <= pop_ff;
			w2_ff <= w1_ff;
			last_ff <= rd_data_o;
		end
	end
	// Ready is held high while wr_held_i is set; otherwise it is pulsed once, then held low until the write strobe shows.
	always_ff @(posedge clk_i)
	begin
		if (reset_i || !wr_en_i)
		begin
			wr_ready_o <= 1'b0;
			waiting_ff <= 1'b0;
		end
		else if (wr_held_i)
		begin
			wr_ready_o <= 1'b1;
		end
		else if (wr_ready_o)
		begin
			wr_ready_o <= 1'b0;
			waiting_ff <= 1'b1;
		end
		else if (!waiting_ff || wr_strobe_i)
		begin
			wr_ready_o <= 1'b1;
			waiting_ff <= 1'b0;
		end
	end
endmodule : pbbr_backend_model

/* File: test/tb.sv */
// Self-checking bench for the backend burst and read-recovery engine.
`timescale 1ns/10ps
module tb;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	pbbr_pkg::pbbr_req_s rd_req_i = '0;
	logic rd_end_i = 1'b0;
	logic rd_take_i = 1'b0;
	logic rd_sync_i = 1'b0;
	logic [31:0] rd_data_o;
	logic rd_valid_o;
	logic be_rd_strobe_o;
	logic [15:0] be_addr_o;
	logic [31:0] be_rd_data_i;
	logic [3:0] retained_count_o;
	logic wr_cycle_i = 1'b0;
	logic pci_irdy_i = 1'b0;
	logic [31:0] wr_data_i = 32'h0;
	logic backend_write_ready_i;
	logic target_ready_o;
	logic backend_write_strobe_o;
	logic [31:0] be_wr_data_o;
	logic wr_en = 1'b0; // Lets the partner pace writes.
	logic wr_held = 1'b0; // Partner holds ready instead of pulsing it.
	int failures = 0;
	int n_compared = 0;
	int n_rd_stb = 0;
	int n_wr_stb = 0;
	logic [31:0] wr_exp = 32'h0;
	logic phase_prev = 1'b0; // A write data phase was accepted at the last edge.
	always #12.5 clk_i = ~clk_i;
	pbbr_core dut (.clk_i(clk_i), .reset_i(reset_i), .rd_req_i(rd_req_i), .rd_end_i(rd_end_i),
		.rd_take_i(rd_take_i), .rd_sync_i(rd_sync_i), .rd_data_o(rd_data_o),
		.rd_valid_o(rd_valid_o), .be_rd_strobe_o(be_rd_strobe_o), .be_addr_o(be_addr_o),
		.be_rd_data_i(be_rd_data_i), .retained_count_o(retained_count_o),
		.wr_cycle_i(wr_cycle_i), .pci_irdy_i(pci_irdy_i), .wr_data_i(wr_data_i),
		.backend_write_ready_i(backend_write_ready_i), .target_ready_o(target_ready_o),
		.backend_write_strobe_o(backend_write_strobe_o), .be_wr_data_o(be_wr_data_o));
	pbbr_backend_model partner (.clk_i(clk_i), .reset_i(reset_i), .rd_sync_i(rd_sync_i),
		.rd_strobe_i(be_rd_strobe_o), .rd_data_o(be_rd_data_i), .wr_en_i(wr_en),
		.wr_held_i(wr_held), .wr_strobe_i(backend_write_strobe_o),
		.wr_ready_o(backend_write_ready_i));
	task automatic tally_and_finish();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check_val
	// Task-driven inputs always move the same short delay after the rising edge; wr_data_i steps at the edge itself.
	task automatic tick();
		@(posedge clk_i);
		#2;
	endtask : tick
	task automatic hang(input string what);
		failures++;
		$display("ERROR %s expected done seen timeout", what);
		tally_and_finish();
	endtask : hang
	// The PCI side moves to its next data word only on an accepted data phase.
	always @(posedge clk_i)
	begin
		if (target_ready_o === 1'b1 && pci_irdy_i)
			wr_data_i <= wr_data_i + 32'h1;
		if (be_rd_strobe_o === 1'b1)
		begin
			check_val("be_addr_o", 32'(n_rd_stb) * 32'h4, 32'(be_addr_o));
			n_rd_stb++;
		end
		if (backend_write_strobe_o === 1'b1)
		begin
			check_val("target_ready_o", 32'h1, 32'(phase_prev));
			check_val("be_wr_data_o", wr_exp, be_wr_data_o);
			wr_exp++;
			n_wr_stb++;
		end
		phase_prev <= (target_ready_o === 1'b1) && (pci_irdy_i === 1'b1);
	end
	task automatic do_reset(input logic sync);
		reset_i = 1'b1;
		rd_sync_i = sync;
		wr_data_i = 32'h0;
		wr_exp = 32'h0;
		repeat (20) tick();
		reset_i = 1'b0;
		n_rd_stb = 0;
		n_wr_stb = 0;
		check_val("rst_valid", 32'h0, 32'(rd_valid_o));
		check_val("rst_count", 32'h0, 32'(retained_count_o));
	endtask : do_reset
	task automatic sc_write_pulse();
		int t;
		do_reset(1'b0);
		wr_cycle_i = 1'b1;
		pci_irdy_i = 1'b1;
		wr_en = 1'b1;
		for (t = 0; t < 80 && n_wr_stb < 4; t++)
			tick();
		if (t == 80)
			hang("write_pulse");
		wr_en = 1'b0;
		check_val("wr_strobes", 32'h4, 32'(n_wr_stb));
		repeat (4) tick();
		wr_cycle_i = 1'b0;
	endtask : sc_write_pulse
	// Ready held for many cycles, then removed: at most two writes may trail it.
	task automatic sc_write_held();
		int snap;
		do_reset(1'b0);
		wr_cycle_i = 1'b1;
		pci_irdy_i = 1'b1;
		wr_en = 1'b1;
		wr_held = 1'b1;
		repeat (10) tick();
		wr_en = 1'b0;
		wr_held = 1'b0;
		// The two strobes right after removal belong to data phases taken while
		// ready still stood, so they are not among the trailing writes.
		repeat (2) tick();
		snap = n_wr_stb;
		check_val("held_writes", 32'h1, 32'(snap > 2));
		repeat (10) tick();
		check_val("extra_writes", 32'h1, 32'((n_wr_stb - snap) <= 2));
		wr_cycle_i = 1'b0;
	endtask : sc_write_held
	task automatic start_read(input logic [2:0] region);
		rd_req_i.start = 1'b1;
		rd_req_i.region = region;
		rd_req_i.addr = 16'h0000;
		tick();
		rd_req_i.start = 1'b0;
	endtask : start_read
	// Take n words in order, then close the PCI read cycle.
	task automatic take_words(input logic [31:0] first, input int n);
		int t;
		for (int k = 0; k < n; k++)
		begin
			for (t = 0; t < 40 && rd_valid_o !== 1'b1; t++)
				tick();
			if (t == 40)
				hang("rd_valid_o");
			check_val("rd_data_o", first + 32'(k), rd_data_o);
			rd_take_i = 1'b1;
			tick();
			rd_take_i = 1'b0;
		end
		rd_end_i = 1'b1;
		tick();
		rd_end_i = 1'b0;
	endtask : take_words
	task automatic wait_count(input logic [3:0] exp);
		int t;
		for (t = 0; t < 30 && retained_count_o !== exp; t++)
			tick();
		repeat (4) tick();
		check_val("retained_count_o", 32'(exp), 32'(retained_count_o));
	endtask : wait_count
	// Recovery region: stalled bus shows the fetch cap, leftovers replay next read.
	task automatic sc_recover(input logic sync, input logic [3:0] keep);
		do_reset(sync);
		start_read(3'h0);
		repeat (12) tick();
		check_val("ahead", 32'(keep), 32'(n_rd_stb));
		take_words(32'h0, 4);
		wait_count(keep);
		check_val("fetched", 32'(keep) + 32'h4, 32'(n_rd_stb));
		start_read(3'h0);
		take_words(32'h4, 4);
		wait_count(keep);
	endtask : sc_recover
	// Plain region: undelivered prefetched words are thrown away.
	task automatic sc_plain();
		do_reset(1'b0);
		start_read(3'h1);
		take_words(32'h0, 4);
		wait_count(4'h0);
		check_val("idle_valid", 32'h0, 32'(rd_valid_o));
	endtask : sc_plain
	initial
	begin
		sc_write_pulse();
		sc_write_held();
		sc_recover(1'b0, pbbr_pkg::LOOKAHEAD_SYNC0);
		sc_recover(1'b1, pbbr_pkg::LOOKAHEAD_SYNC1);
		sc_plain();
		tally_and_finish();
	end
endmodule : tb
